//--- dv/brs_rom_model.sv
// serial rom engine model feeding the preload word port
`timescale 1ns/1ps
module brs_rom_model (
    input wire sys_clk, // clock
    input wire reset_n, // reset, low
    input wire rom_start, // begin image
    input wire slow, // gap between words
    input wire [199:0] img, // five offset and word pairs
    output reg rom_valid, // word strobe
    output reg [7:0] rom_addr, // word offset
    output reg [31:0] rom_data, // word value
    output reg rom_done // image end
);
    integer idx;
    integer gap;
    // walks the image one word per strobe; idle lines flip every cycle
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            idx <= -1;
            gap <= 0;
            rom_valid <= 1'b0;
            rom_done <= 1'b0;
            rom_addr <= 8'hA5;
            rom_data <= 32'h5A5A5A5A;
        end else begin
            rom_valid <= 1'b0;
            rom_done <= 1'b0;
            rom_addr <= ~rom_addr;
            rom_data <= ~rom_data;
            if (rom_start) begin
                idx <= 0;
                gap <= 2;
            end else if (idx >= 0 && gap > 0) begin
                gap <= gap - 1;
            end else if (idx >= 0 && idx < 5) begin
                rom_valid <= 1'b1;
                {rom_addr, rom_data} <= img[idx*40 +: 40];
                idx <= idx + 1;
                gap <= slow ? 3 : 0;
            end else if (idx == 5) begin
                rom_done <= 1'b1;
                idx <= -1;
            end
        end
    end
endmodule

//--- dv/brs_top_props.sv
// concurrent checks on the reset, strap, preload and lockout ports
`timescale 1ns/1ps
module brs_top_props #(
    parameter [15:0] PRELOAD_CYC = 16'h0014
) (
    input wire sys_clk, // clock
    input wire reset_n, // reset, low
    input wire [4:0] primary_addr_data_straps, // straps
    input wire cfg_req, // request
    input wire cfg_from_sec, // local side
    input wire cfg_ack_q, // accepted
    input wire cfg_retry_q, // retried
    input wire rom_start_q, // rom start
    input wire pl_wr_valid_q, // preload write
    input wire [7:0] pl_wr_addr_q, // write offset
    input wire prim_sm_rst_q, // primary machine reset
    input wire sec_sm_rst_q, // secondary machine reset
    input wire reg_rst_q, // register reset
    input wire buf_rst_q, // buffer reset
    input wire sec_rst_n_q, // secondary bus reset
    input wire secondary_wide_request_n_q, // wide request
    input wire sec_park_oe_q, // bus parking
    input wire sec_arb_en_q, // arbiter on
    input wire sync_mode_q, // sync clocking
    input wire sec_clk_o_q, // secondary clock
    input wire preload_busy_q, // preload running
    input wire lockout_q // lockout bit
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    reg [15:0] pl_cnt_q;
    reg [15:0] rst_len_q;
    // ****************************************
    // preload and chip reset lengths
    // ****************************************
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pl_cnt_q <= 16'h0000;
            rst_len_q <= 16'h8000;
        end else begin
            pl_cnt_q <= (preload_busy_q && !reg_rst_q) ?
                pl_cnt_q + 16'h0001 : 16'h0000;
            rst_len_q <= reg_rst_q ? rst_len_q + 16'h0001 : 16'h0000;
        end
    end
    a_answer_once: assert property (cfg_req |=> cfg_ack_q != cfg_retry_q)
        else $error("config request not answered once");
    a_preload_retry: assert property (cfg_req && preload_busy_q |=> cfg_retry_q)
        else $error("access accepted during preload");
    a_lockout_retry: assert property (cfg_req && !cfg_from_sec && lockout_q
        |=> cfg_retry_q) else $error("host accepted under lockout");
    a_local_access: assert property (cfg_req && cfg_from_sec
        && !preload_busy_q && !reg_rst_q |=> cfg_ack_q)
        else $error("local access refused");
    a_reset_entry: assert property ($rose(reset_n) |-> !sec_rst_n_q
        && reg_rst_q && prim_sm_rst_q && sec_sm_rst_q && buf_rst_q)
        else $error("primary reset did not reset all");
    a_rst_map: assert property ((!$past(reset_n, 2)
        || sec_rst_n_q == !sec_sm_rst_q)
        && buf_rst_q == sec_sm_rst_q && prim_sm_rst_q == reg_rst_q
        && (!reg_rst_q || sec_sm_rst_q)) else $error("reset outputs apart");
    a_chip_len: assert property ($fell(reg_rst_q) && !rst_len_q[15]
        |-> rst_len_q > 16'h0F8C && rst_len_q < 16'h0FB4)
        else $error("chip reset length");
    a_preload_start: assert property ($fell(reg_rst_q) |->
        preload_busy_q ##[0:1] rom_start_q) else $error("no preload start");
    a_no_sec_pl: assert property (sec_sm_rst_q && !reg_rst_q |->
        !rom_start_q && !preload_busy_q) else $error("preload on sec reset");
    a_wr_filter: assert property (pl_wr_valid_q |->
        !(pl_wr_addr_q inside {[8'h04:8'h07], [8'h0C:8'h27]}))
        else $error("preload wrote a software register");
    a_pl_bound: assert property (pl_cnt_q <= PRELOAD_CYC + 16'h0004)
        else $error("preload too long");
    a_strap_mode: assert property ($past(reset_n) |->
        sec_arb_en_q == primary_addr_data_straps[4]
        && sync_mode_q == !primary_addr_data_straps[1])
        else $error("mode straps not applied");
    a_sclk_off: assert property (!primary_addr_data_straps[2] |->
        !sec_clk_o_q) else $error("secondary clock not held low");
    a_park_on: assert property ($past(reset_n) && !sec_rst_n_q
        && !primary_addr_data_straps[3] |-> sec_park_oe_q
        && !secondary_wide_request_n_q) else $error("bus not parked");
    a_park_off: assert property (sec_rst_n_q || primary_addr_data_straps[3]
        |-> !sec_park_oe_q && secondary_wide_request_n_q)
        else $error("bus parked outside reset");
endmodule
bind brs_top brs_top_props #(.PRELOAD_CYC(PRELOAD_CYC)) i_brs_top_props (
    .sys_clk, .reset_n, .primary_addr_data_straps, .cfg_req, .cfg_from_sec,
    .cfg_ack_q, .cfg_retry_q, .rom_start_q, .pl_wr_valid_q, .pl_wr_addr_q,
    .prim_sm_rst_q, .sec_sm_rst_q, .reg_rst_q, .buf_rst_q, .sec_rst_n_q,
    .secondary_wide_request_n_q, .sec_park_oe_q, .sec_arb_en_q,
    .sync_mode_q, .sec_clk_o_q, .preload_busy_q, .lockout_q);

//--- dv/brs_top_tb.sv
// self-checking bench for the reset, preload and lockout sequencer
`timescale 1ns/1ps
module brs_top_tb;
    reg sys_clk = 1'b0;
    reg reset_n = 1'b0;
    reg [4:0] straps = 5'h00;
    reg cfg_req = 1'b0;
    reg cfg_from_sec = 1'b0;
    reg cfg_we = 1'b0;
    reg [7:0] cfg_addr = 8'h00;
    reg [31:0] cfg_wdata = 32'h00000000;
    reg slow = 1'b0;
    reg [199:0] img = 200'h0;
    reg [31:0] seed = 32'h90D9;
    reg [39:0] exp_q [$];
    integer n_fail = 0;
    integer checks = 0;
    integer i;
    integer k;
    wire rom_valid, rom_done, cfg_ack_q, cfg_retry_q, rom_start_q;
    wire pl_wr_valid_q, prim_sm_rst_q, sec_sm_rst_q, reg_rst_q, buf_rst_q;
    wire sec_rst_n_q, wide_n, park, sec_arb_en_q, sync_mode_q;
    wire sec_clk_o_q, preload_busy_q, lockout_q;
    wire [7:0] rom_addr, pl_wr_addr_q;
    wire [31:0] rom_data, cfg_rdata_q, pl_wr_data_q;
    // ****************************************
    // clock, design and rom engine
    // ****************************************
    always #12.5 sys_clk = ~sys_clk;
    brs_top #(.PRELOAD_CYC(16'h0040)) i_brs_top (.sys_clk, .reset_n,
        .primary_addr_data_straps(straps), .cfg_req, .cfg_from_sec, .cfg_we,
        .cfg_addr, .cfg_wdata, .rom_valid, .rom_addr, .rom_data, .rom_done,
        .cfg_ack_q, .cfg_retry_q, .cfg_rdata_q, .rom_start_q, .pl_wr_valid_q,
        .pl_wr_addr_q, .pl_wr_data_q, .prim_sm_rst_q, .sec_sm_rst_q,
        .reg_rst_q, .buf_rst_q, .sec_rst_n_q, .sec_park_oe_q(park),
        .secondary_wide_request_n_q(wide_n), .sec_arb_en_q, .sync_mode_q,
        .sec_clk_o_q, .preload_busy_q, .lockout_q);
    brs_rom_model i_brs_rom_model (.sys_clk, .reset_n, .rom_start(rom_start_q),
        .slow, .img, .rom_valid, .rom_addr, .rom_data, .rom_done);
    // ****************************************
    // helpers
    // ****************************************
    function [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction
    function ok_off(input [7:0] a);
        ok_off = !((a >= 8'h04 && a <= 8'h07) || (a >= 8'h0C && a <= 8'h27));
    endfunction
    task chk(input logic [39:0] g, input logic [39:0] e);
        checks = checks + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task conclude;
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one access: driven at the next edge, answered one edge later
    task cfg(input s, input w, input [7:0] a, input [31:0] d, input ea,
             input [31:0] er);
        @(posedge sys_clk);
        cfg_req <= 1'b1;
        cfg_from_sec <= s;
        cfg_we <= w;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_req <= 1'b0;
        #1;
        chk({cfg_ack_q, cfg_retry_q}, {ea, !ea});
        if (ea && !w) chk(cfg_rdata_q, er);
    endtask
    // model of expected preload writes, checked at every strobe
    always @(posedge sys_clk) begin
        if (rom_start_q === 1'b1)
            for (k = 0; k < 5; k = k + 1)
                if (ok_off(img[k*40+32 +: 8])) exp_q.push_back(img[k*40 +: 40]);
        if (pl_wr_valid_q === 1'b1) begin
            if (exp_q.size() == 0) chk(pl_wr_addr_q, 8'hFF);
            else chk({pl_wr_addr_q, pl_wr_data_q}, exp_q.pop_front());
        end
    end
    task wait_pl;
        integer n;
        n = 0;
        while (preload_busy_q !== 1'b0 && n < 6000) begin
            @(posedge sys_clk);
            #1;
            n = n + 1;
        end
        chk(n < 6000, 1'b1);
        chk(exp_q.size(), 0);
    endtask
    task host_flow;
        cfg(0, 0, 8'hDC, 0, 0, 0);
        cfg(1, 0, 8'hDC, 0, 1, 32'h00000001);
        cfg(1, 0, 8'h40, 0, 1, 0);
        cfg(1, 1, 8'hDC, 0, 1, 0);
        cfg(0, 0, 8'hDC, 0, 1, 0);
    endtask
    task do_rst(input [4:0] s);
        logic b;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        straps <= s;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        b = sec_clk_o_q;
        chk(lockout_q, s[0]);
        chk({sec_arb_en_q, sync_mode_q}, {s[4], !s[1]});
        @(posedge sys_clk);
        #1;
        chk(sec_clk_o_q, s[2] ? !b : 1'b0);
        cfg(1, 0, 8'hD8, 0, 0, 0);
        wait_pl;
    endtask
    task chip_wait(input lk);
        integer n;
        n = 0;
        repeat (10) @(posedge sys_clk);
        #1;
        chk({reg_rst_q, buf_rst_q, sec_rst_n_q, lockout_q}, {3'b110, lk});
        while (sec_rst_n_q !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            #1;
            n = n + 1;
        end
        chk(n > 3980 && n < 4000, 1'b1);
        wait_pl;
        host_flow;
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            img[i*40 +: 40] = {8'(32'h040C14B0 >> (24 - 8 * i)), seed};
        end
        img[160 +: 40] = {8'hDC, 32'h00000001};
        for (i = 0; i < 3; i = i + 1) begin
            if (!i[0]) seed = xs(seed);
            do_rst(seed[4:0] ^ {5{i[0]}});
            host_flow;
        end
        cfg(1, 1, 8'hD8, 32'h00000001, 1, 0);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({sec_rst_n_q, buf_rst_q, reg_rst_q, preload_busy_q}, 4'h4);
        cfg(1, 0, 8'hD8, 0, 1, 32'h00000001);
        cfg(1, 1, 8'hD8, 0, 1, 0);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({sec_rst_n_q, buf_rst_q}, 2'b10);
        @(posedge sys_clk);
        slow <= 1'b1;
        cfg(1, 1, 8'hD8, 32'h00000002, 1, 0);
        chip_wait(straps[0]);
        cfg(1, 1, 8'hE0, 32'h00000003, 1, 0);
        cfg(1, 0, 8'hE0, 0, 1, 32'h00000003);
        cfg(1, 1, 8'hE0, 0, 1, 0);
        chip_wait(straps[0]);
        conclude;
    end
    initial begin
        #(25 * 40000);
        n_fail = n_fail + 1;
        conclude;
    end
endmodule

//--- hdl/brs_preload.v
// serial rom preload sequencer with write filter and timeout
`timescale 1ns/1ps
`include "brs_regs.vh"
module brs_preload #(
    parameter [15:0] LIMIT = 16'h5910
) (
    input wire sys_clk,           // system clock
    input wire reset_n,           // async reset, active low
    input wire start,             // one-cycle start pulse
    input wire rom_valid,         // rom engine offers a word
    input wire [7:0] rom_addr,    // target config offset
    input wire [31:0] rom_data,   // word to load
    input wire rom_done,          // rom engine finished image
    output reg rom_start_q,       // pulse asking rom engine to begin
    output reg busy_q,            // preload running
    output reg done_q,            // one-cycle pulse at end
    output reg wr_valid_q,        // filtered preload write
    output reg [7:0] wr_addr_q,   // write offset
    output reg [31:0] wr_data_q   // write data
);

reg [15:0] cnt_q;
reg allowed;

// ****************************************
// write filter
// ****************************************
// command, cache line / latency and bars stay for software
always @* begin
    allowed = 1'b1;
    if (rom_addr[7:2] == `BRS_OFF_COMMAND >> 2) begin
        allowed = 1'b0; // RQ13
    end
    if (rom_addr[7:2] == `BRS_OFF_CACHE_LAT >> 2) begin
        allowed = 1'b0; // RQ13
    end
    if (rom_addr >= `BRS_OFF_BAR_FIRST && rom_addr <= `BRS_OFF_BAR_LAST) begin
        allowed = 1'b0; // RQ13
    end
end

// ****************************************
// sequencer
// ****************************************
// run until the rom engine is done or the interval expires
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        cnt_q <= 16'h0000;
        busy_q <= 1'b0;
        done_q <= 1'b0;
        rom_start_q <= 1'b0;
        wr_valid_q <= 1'b0;
        wr_addr_q <= 8'h00;
        wr_data_q <= `BRS_WORD_ZERO;
    end else begin
        done_q <= 1'b0;
        rom_start_q <= 1'b0;
        wr_valid_q <= 1'b0;
        if (start) begin
            busy_q <= 1'b1; // RQ6
            rom_start_q <= 1'b1; // RQ11
            cnt_q <= 16'h0001;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 16'h0001;
            if (rom_valid && allowed) begin
                wr_valid_q <= 1'b1; // RQ12
                wr_addr_q <= rom_addr;
                wr_data_q <= rom_data;
            end
            if (rom_done || cnt_q >= LIMIT) begin
                busy_q <= 1'b0; // RQ14
                done_q <= 1'b1;
            end
        end
    end
end

endmodule

//--- hdl/brs_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef BRS_REGS_VH
`define BRS_REGS_VH

// ****************************************
// configuration offsets
// ****************************************
`define BRS_OFF_RESET_CONTROL 8'hD8
`define BRS_OFF_POWER_STATE 8'hE0
`define BRS_OFF_CHIP_CONTROL 8'hDC
`define BRS_OFF_COMMAND 8'h04
`define BRS_OFF_CACHE_LAT 8'h0C
`define BRS_OFF_BAR_FIRST 8'h10
`define BRS_OFF_BAR_LAST 8'h27

// ****************************************
// field positions and values
// ****************************************
`define BRS_RC_SEC_BIT 0
`define BRS_RC_CHIP_BIT 1
`define BRS_CC_LOCKOUT_BIT 0
`define BRS_PM_D0 2'h0
`define BRS_PM_D3 2'h3
`define BRS_STRAP_ARB 4
`define BRS_STRAP_CENTRAL 3
`define BRS_STRAP_SCLK 2
`define BRS_STRAP_SYNC 1
`define BRS_STRAP_LOCK 0
`define BRS_WORD_ZERO 32'h00000000

// ****************************************
// timing
// ****************************************
`define BRS_CHIP_RST_CYC 16'h0FA0
`define BRS_PRELOAD_CYC 16'h5910

`endif

//--- hdl/brs_timer.v
// one-shot interval timer that pulses done a fixed count after start
`timescale 1ns/1ps
module brs_timer #(
    parameter [15:0] CYCLES = 16'h0FA0
) (
    input wire sys_clk,    // system clock
    input wire reset_n,    // async reset, active low
    input wire start,      // one-cycle start pulse
    output reg busy_q,     // interval running
    output reg done_q      // one-cycle pulse at end of interval
);

reg [15:0] cnt_q;

// ****************************************
// counter
// ****************************************
// count up from start; restart on a new start pulse
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        cnt_q <= 16'h0000;
        busy_q <= 1'b0;
        done_q <= 1'b0;
    end else begin
        done_q <= 1'b0;
        if (start) begin
            cnt_q <= 16'h0001;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (cnt_q >= CYCLES) begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
    end
end

endmodule

//--- hdl/brs_top.v
// bridge reset, strap capture, preload and lockout sequencer
// Functional notes
// [RQ1] primary reset clears all state and holds secondary reset until release
// [RQ2] secondary reset output asserted under every reset source, released with it
// [RQ3] chip reset bit gives full reset plus preload, self-releasing near 100 us
// [RQ4] power state D3 to D0 gives full reset plus preload, about 100 us
// [RQ5] secondary reset bit resets secondary side and buffers only, no preload
// [RQ6] every reset except secondary bit starts preload after chip reset
// [RQ7] five straps latched at reset; arbiter and sync mode selected
// [RQ8] central strap low drives wide request and bus low during secondary reset
// [RQ9] secondary clock runs when strap high, held low otherwise
// [RQ10] strap sets primary lockout reset value; lockout retries primary config
// [RQ11] after chip reset and secondary release, serial rom read begins
// [RQ12] preload loads setup, id, control, arbiter, error and power fields
// [RQ13] preload never writes command, bars, cache line or latency registers
// [RQ14] every config access retried while preload runs, about 570 us
// [RQ15] lockout retries host side but local side still gets access
// [RQ16] local processor clears lockout bit when setup is finished
// [RQ17] local processor releases lockout within 2^25 primary clocks
// [RQ18] secondary reset is driven output; secondary bus cannot reset device
// [RQ19] after lockout clears host reaches primary and device registers
// [RQ20] auto release interval counted on primary clock
`timescale 1ns/1ps
`include "brs_regs.vh"
module brs_top #(
    parameter [15:0] PRELOAD_CYC = `BRS_PRELOAD_CYC
) (
    input wire sys_clk,                            // primary clock
    input wire reset_n,                            // primary bus reset
    input wire [4:0] primary_addr_data_straps,     // mode straps 7..3
    input wire cfg_req,                            // config access pulse
    input wire cfg_from_sec,                       // access from local side
    input wire cfg_we,                             // write when high
    input wire [7:0] cfg_addr,                     // config offset
    input wire [31:0] cfg_wdata,                   // write data
    input wire rom_valid,                          // rom word offered
    input wire [7:0] rom_addr,                     // rom word offset
    input wire [31:0] rom_data,                    // rom word data
    input wire rom_done,                           // rom image finished
    output reg cfg_ack_q,                          // access accepted
    output reg cfg_retry_q,                        // access gets retry
    output reg [31:0] cfg_rdata_q,                 // read data
    output wire rom_start_q,                       // start rom read pulse
    output wire pl_wr_valid_q,                     // preload write strobe
    output wire [7:0] pl_wr_addr_q,                // preload write offset
    output wire [31:0] pl_wr_data_q,               // preload write data
    output reg prim_sm_rst_q,                      // primary machine reset
    output reg sec_sm_rst_q,                       // secondary machine reset
    output reg reg_rst_q,                          // register reset
    output reg buf_rst_q,                          // data buffer reset
    output reg sec_rst_n_q,                        // secondary bus reset
    output reg secondary_wide_request_n_q,         // wide request, low
    output reg sec_park_oe_q,                      // drive bus lines low
    output reg sec_arb_en_q,                       // secondary arbiter on
    output reg sync_mode_q,                        // synchronous clocking
    output reg sec_clk_o_q,                        // secondary clock out
    output reg preload_busy_q,                     // preload running
    output reg lockout_q                           // primary lockout bit
);

// ****************************************
// states
// ****************************************
localparam [1:0] ST_LATCH = 2'b00;
localparam [1:0] ST_CHIP = 2'b01;
localparam [1:0] ST_PRELOAD = 2'b10;
localparam [1:0] ST_RUN = 2'b11;

reg [1:0] st_q;
reg [1:0] st_d;
reg [4:0] strap_q;
reg rc_sec_q;
reg rc_sec_d;
reg [31:0] pm_q;
reg [31:0] cc_q;
reg sclk_en_q;
reg central_q;
reg chip_go;
reg pl_go;
reg [31:0] rd_word;
wire cfg_ok;
wire wr_rc;
wire wr_pm;
wire wr_cc;
wire chip_req;
wire tmr_done;
wire pl_done;
wire sec_act_d;
wire chip_act_d;
wire central_now;
wire sclk_now;

// ****************************************
// access decode
// ****************************************
// only a settled bridge answers; lockout shuts out the host side
assign cfg_ok = cfg_req && (st_q == ST_RUN) && // RQ14
    (cfg_from_sec || !cc_q[`BRS_CC_LOCKOUT_BIT]); // RQ15 RQ19
assign wr_rc = cfg_ok && cfg_we && (cfg_addr == `BRS_OFF_RESET_CONTROL);
assign wr_pm = cfg_ok && cfg_we && (cfg_addr == `BRS_OFF_POWER_STATE);
assign wr_cc = cfg_ok && cfg_we && (cfg_addr == `BRS_OFF_CHIP_CONTROL);

// chip reset bit or power state D3 to D0 request a full reset
assign chip_req = (wr_rc && cfg_wdata[`BRS_RC_CHIP_BIT]) || // RQ3
    (wr_pm && pm_q[1:0] == `BRS_PM_D3 &&
    cfg_wdata[1:0] == `BRS_PM_D0); // RQ4

// ****************************************
// sequence
// ****************************************
// latch, preload, run; a chip reset goes from run to the chip reset interval, then preload
always @* begin
    st_d = st_q;
    chip_go = 1'b0;
    pl_go = 1'b0;
    case (st_q)
        ST_LATCH: begin
            st_d = ST_PRELOAD;
            pl_go = 1'b1; // RQ6
        end
        ST_CHIP: begin
            if (tmr_done) begin
                st_d = ST_PRELOAD;
                pl_go = 1'b1; // RQ6 RQ11
            end
        end
        ST_PRELOAD: begin
            if (pl_done) begin
                st_d = ST_RUN;
            end
        end
        ST_RUN: begin
            if (chip_req) begin
                st_d = ST_CHIP;
                chip_go = 1'b1;
            end
        end
        default: begin
            st_d = ST_LATCH;
        end
    endcase
end

// secondary reset bit; a chip reset clears it
always @* begin
    rc_sec_d = rc_sec_q;
    if (chip_go) begin
        rc_sec_d = 1'b0;
    end else if (wr_rc) begin
        rc_sec_d = cfg_wdata[`BRS_RC_SEC_BIT]; // RQ5
    end
end

// reset activity for the next cycle
assign chip_act_d = (st_d == ST_CHIP);
assign sec_act_d = chip_act_d || (st_q == ST_LATCH) || rc_sec_d; // RQ2

// straps are read live on the latch cycle, stored afterwards
assign central_now = (st_q == ST_LATCH) ?
    !primary_addr_data_straps[`BRS_STRAP_CENTRAL] : central_q;
assign sclk_now = (st_q == ST_LATCH) ?
    primary_addr_data_straps[`BRS_STRAP_SCLK] : sclk_en_q;

// ****************************************
// read mux
// ****************************************
always @* begin
    rd_word = `BRS_WORD_ZERO;
    case (cfg_addr)
        `BRS_OFF_RESET_CONTROL: begin
            rd_word[`BRS_RC_SEC_BIT] = rc_sec_q;
        end
        `BRS_OFF_POWER_STATE: begin
            rd_word = pm_q;
        end
        `BRS_OFF_CHIP_CONTROL: begin
            rd_word = cc_q;
        end
        default: begin
            rd_word = `BRS_WORD_ZERO;
        end
    endcase
end

// ****************************************
// state and registers
// ****************************************
// primary reset asserts every reset output and clears the state
always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        st_q <= ST_LATCH; // RQ1
        strap_q <= 5'h00;
        central_q <= 1'b0;
        sclk_en_q <= 1'b0;
        rc_sec_q <= 1'b0;
        pm_q <= `BRS_WORD_ZERO;
        cc_q <= `BRS_WORD_ZERO;
        prim_sm_rst_q <= 1'b1; // RQ1
        sec_sm_rst_q <= 1'b1; // RQ1
        reg_rst_q <= 1'b1; // RQ1
        buf_rst_q <= 1'b1; // RQ1
        sec_rst_n_q <= 1'b0; // RQ1
        secondary_wide_request_n_q <= 1'b1;
        sec_park_oe_q <= 1'b0;
        sec_arb_en_q <= 1'b0;
        sync_mode_q <= 1'b0;
        sec_clk_o_q <= 1'b0;
        preload_busy_q <= 1'b0;
        lockout_q <= 1'b0;
        cfg_ack_q <= 1'b0;
        cfg_retry_q <= 1'b0;
        cfg_rdata_q <= `BRS_WORD_ZERO;
    end else begin
        st_q <= st_d;
        rc_sec_q <= rc_sec_d;
        // straps caught on the first edge after primary release
        if (st_q == ST_LATCH) begin
            strap_q <= primary_addr_data_straps; // RQ7
            central_q <= central_now;
            sclk_en_q <= sclk_now;
            sec_arb_en_q <= primary_addr_data_straps[`BRS_STRAP_ARB]; // RQ7
            sync_mode_q <= !primary_addr_data_straps[`BRS_STRAP_SYNC]; // RQ7
            cc_q[`BRS_CC_LOCKOUT_BIT] <=
                primary_addr_data_straps[`BRS_STRAP_LOCK]; // RQ10
        end
        // chip reset restores registers, lockout from stored strap
        if (chip_go) begin
            pm_q <= `BRS_WORD_ZERO; // RQ3 RQ4
            cc_q <= `BRS_WORD_ZERO;
            cc_q[`BRS_CC_LOCKOUT_BIT] <= strap_q[`BRS_STRAP_LOCK]; // RQ10
        end else if (pl_wr_valid_q) begin
            // preload fills local control and power capability fields
            if (pl_wr_addr_q == `BRS_OFF_CHIP_CONTROL) begin
                cc_q <= pl_wr_data_q; // RQ12
            end
            if (pl_wr_addr_q == `BRS_OFF_POWER_STATE) begin
                pm_q[31:2] <= pl_wr_data_q[31:2]; // RQ12
            end
        end else begin
            if (wr_pm) begin
                pm_q <= cfg_wdata;
            end
            if (wr_cc) begin
                cc_q <= cfg_wdata; // RQ16
            end
        end
        // reset outputs follow the next state
        prim_sm_rst_q <= chip_act_d; // RQ3 RQ4
        reg_rst_q <= chip_act_d;
        sec_sm_rst_q <= chip_act_d || rc_sec_d; // RQ5
        buf_rst_q <= chip_act_d || rc_sec_d; // RQ5
        sec_rst_n_q <= !sec_act_d; // RQ2 RQ18
        // central function parks the secondary bus during its reset
        secondary_wide_request_n_q <= !(central_now && sec_act_d); // RQ8
        sec_park_oe_q <= central_now && sec_act_d; // RQ8
        // divided secondary clock, held low when strapped off
        sec_clk_o_q <= sclk_now ? !sec_clk_o_q : 1'b0; // RQ9
        preload_busy_q <= (st_d == ST_PRELOAD); // RQ14
        lockout_q <= (st_q == ST_LATCH) ?
            primary_addr_data_straps[`BRS_STRAP_LOCK] :
            cc_q[`BRS_CC_LOCKOUT_BIT];
        // one-cycle answer to every access
        cfg_ack_q <= cfg_ok;
        cfg_retry_q <= cfg_req && !cfg_ok; // RQ14 RQ15
        cfg_rdata_q <= (cfg_ok && !cfg_we) ? rd_word : `BRS_WORD_ZERO;
    end
end

// ****************************************
// submodules
// ****************************************
// self-releasing chip reset interval on the primary clock
brs_timer #(
    .CYCLES(`BRS_CHIP_RST_CYC) // RQ20
) u_chip_tmr (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(chip_go),
    .busy_q(),
    .done_q(tmr_done)
);

// serial rom preload with write filter
brs_preload #(
    .LIMIT(PRELOAD_CYC)
) u_preload (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(pl_go),
    .rom_valid(rom_valid),
    .rom_addr(rom_addr),
    .rom_data(rom_data),
    .rom_done(rom_done),
    .rom_start_q(rom_start_q),
    .busy_q(),
    .done_q(pl_done),
    .wr_valid_q(pl_wr_valid_q),
    .wr_addr_q(pl_wr_addr_q),
    .wr_data_q(pl_wr_data_q)
);

endmodule
